// ===== design/timer_cmp_pkg.sv
package timer_cmp_pkg;

   // ***************************************************************
   // Register map, byte addresses on the APB
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_COUNT   = 8'h04;
   localparam logic [7:0] ADDR_CMP_A   = 8'h08;
   localparam logic [7:0] ADDR_CMP_B   = 8'h0C;
   localparam logic [7:0] ADDR_ACTION  = 8'h10;
   localparam logic [7:0] ADDR_FORCE   = 8'h14;
   localparam logic [7:0] ADDR_FLAGS   = 8'h18;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h1C;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int unsigned CTRL_WGM_LSB  = 0;
   localparam int unsigned CTRL_RUN_BIT  = 3;
   localparam int unsigned ACT_A_LSB     = 0;
   localparam int unsigned ACT_B_LSB     = 2;
   localparam int unsigned CH_A          = 0;
   localparam int unsigned CH_B          = 1;
   localparam int unsigned FLAG_WRAP_BIT = 2;

   // ***************************************************************
   // Reset values and counter limits
   // ***************************************************************
   localparam logic [7:0] CNT_MAX     = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM  = 8'h00;
   localparam logic [7:0] CNT_ONE     = 8'h01;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [2:0] RST_FLAGS   = 3'h0;
   localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

   // ***************************************************************
   // Waveform select codes and output actions
   // ***************************************************************
   localparam logic [2:0] WGM_NORMAL    = 3'h0;
   localparam logic [2:0] WGM_PHASE_MAX = 3'h1;
   localparam logic [2:0] WGM_CTC       = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
   localparam logic [2:0] WGM_PHASE_CMP = 3'h5;
   localparam logic [2:0] WGM_FAST_CMP  = 3'h7;

   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

   typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

   // Per-channel controls from the register file
   typedef struct packed {
      logic [1:0] action;
      logic       forceMatchStrobe;
      logic       flagClear;
      logic       wrEn;
      logic [7:0] wrData;
   } chan_ctl_s;

   // Shared counter state seen by both channels
   typedef struct packed {
      logic       tick;
      logic [7:0] count;
      logic       dblBuf;
      logic       pwmFast;
      logic       pwmPhase;
      logic       countDown;
      logic       updateNow;
      logic       bottomEvt;
      logic       block;
   } tmr_info_s;

endpackage

// ===== design/compare_channel.sv
`timescale 1ns/1ps
`default_nettype none

module compare_channel (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire timer_cmp_pkg::tmr_info_s info,
   input  wire timer_cmp_pkg::chan_ctl_s ctl,
   output logic [7:0]                    compareActive,
   output logic [7:0]                    compareRead,
   output logic                          matchFlag,
   output logic                          outputState
);

   logic [7:0] buf_q, buf_d, act_q, act_d;
   logic       flag_q, flag_d, state_q, state_d;
   logic       realMatch, forced, hit;

   // ***************************************************************
   // Comparator, buffer, flag and waveform generator
   // ***************************************************************
   always_comb begin
      realMatch = info.tick & (info.count == act_q) & ~info.block;
      forced    = ctl.forceMatchStrobe & ~info.dblBuf;
      hit       = realMatch | forced;
      buf_d     = ctl.wrEn ? ctl.wrData : buf_q;
      act_d     = act_q;
      if (ctl.wrEn && !info.dblBuf) begin
         act_d = ctl.wrData;
      end else if (info.dblBuf && info.updateNow) begin
         act_d = buf_q;
      end
      flag_d  = realMatch | (flag_q & ~ctl.flagClear);
      state_d = state_q;
      unique case (ctl.action)
         timer_cmp_pkg::ACT_NONE: state_d = state_q;
         timer_cmp_pkg::ACT_TOGGLE: begin
            if (hit) state_d = ~state_q;
         end
         timer_cmp_pkg::ACT_CLEAR, timer_cmp_pkg::ACT_SET: begin
            if (info.pwmPhase) begin
               if (hit) state_d = info.countDown ^ (ctl.action == timer_cmp_pkg::ACT_SET);
            end else begin
               if (hit) state_d = (ctl.action == timer_cmp_pkg::ACT_SET);
               // Bottom action applied last so compare at MAX gives a flat level
               if (info.pwmFast && info.bottomEvt) begin
                  state_d = (ctl.action == timer_cmp_pkg::ACT_CLEAR);
               end
            end
         end
      endcase
   end

   // Register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_q   <= timer_cmp_pkg::RST_BYTE;
         act_q   <= timer_cmp_pkg::RST_BYTE;
         flag_q  <= 1'b0;
         state_q <= 1'b0;
      end else begin
         buf_q   <= buf_d;
         act_q   <= act_d;
         flag_q  <= flag_d;
         state_q <= state_d;
      end
   end

   assign compareActive = act_q;
   assign compareRead   = info.dblBuf ? buf_q : act_q;
   assign matchFlag     = flag_q;
   assign outputState   = state_q;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   flag_after_match_a: assert property (
      (info.tick && info.count == act_q && !info.block) |=> flag_q)
      else $error("match flag not set one cycle after match");

   force_no_flag_a: assert property (
      (forced && !realMatch && !flag_q) |=> !flag_q)
      else $error("forced match set the match flag");

   action_none_hold_a: assert property (
      (ctl.action == timer_cmp_pkg::ACT_NONE) |=> (state_q == $past(state_q)))
      else $error("output state changed with no action selected");

   buffered_hold_a: assert property (
      (info.dblBuf && !info.updateNow) |=> (act_q == $past(act_q)))
      else $error("active compare changed away from top or bottom");

endmodule // compare_channel

`default_nettype wire

// ===== design/timer_compare_output_unit.sv
// Function
// - Compare the 8-bit counter with each channel compare value continuously.
// - Set a channel match flag one timer cycle after equality.
// - An enabled channel with its flag set raises a compare interrupt request.
// - Interrupt service or writing one clears the match flag.
// - Waveform generator acts on match per mode, using max and bottom events.
// - Compare value is double buffered in PWM modes only.
// - Buffered value moves to active compare only at top or bottom.
// - CPU reaches the buffer when buffered, else the active compare directly.
// - Force strobe makes a comparator match in non-PWM modes.
// - Forced match sets no flag, leaves counter, but updates output state.
// - A counter write blocks compare matches in the next timer cycle.
// - Output state keeps its value across waveform mode changes.
// - Output action setting is unbuffered; applies from next compare match.
// - Any nonzero output action overrides the port output; direction stays port's.
// - Output action zero leaves output state unchanged on a match.
// - Only waveform select shapes counting; action picks polarity or set/clear/toggle.
// - Normal mode counts up only, wrapping from 0xFF to 0x00.
// - Normal mode sets wrap flag as counter becomes zero; cleared on service.
// - Normal mode accepts counter writes at any time.
// - Waveform select 2 clears the counter on channel A compare match.
// - Select 3 or 7 is fast PWM, top MAX or channel A compare.
// - Select 1 or 5 is phase correct PWM, top MAX or channel A compare.
`timescale 1ns/1ps
`default_nettype none

module timer_compare_output_unit (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  irqAck,
   output logic [2:0]       irqReq,
   input  wire logic [1:0]  portOut,
   input  wire logic [1:0]  outputPinDirectionBit,
   output logic [1:0]       pinOut,
   output logic [1:0]       pinOe
);

   logic [2:0]  waveformSelect_q, waveformSelect_d;
   logic        run_q, run_d;
   logic [3:0]  outputActionSelect_q, outputActionSelect_d;
   logic [2:0]  irqEn_q, irqEn_d;
   logic        wrapFlag_q, wrapFlag_d;
   logic [7:0]  counterValue_q, counterValue_d;
   logic        block_q, block_d;
   logic [31:0] prdata_q, prdata_d;
   timer_cmp_pkg::dir_e dir_q, dir_d;

   logic        wrStrobe, rdSetup, addrOk, cntWrite;
   logic        modeNormal, modeCtc, modeFast, modePhase, topFromA;
   logic [7:0]  topValue;
   logic        atTop, atBottom, wrapEvt;
   logic [1:0]  matchFlag, outputState;
   logic [7:0]  compareActiveA, compareReadA, compareReadB;
   timer_cmp_pkg::tmr_info_s info;
   timer_cmp_pkg::chan_ctl_s ctlA, ctlB;

   // ***************************************************************
   // APB decode
   // ***************************************************************
   always_comb begin
      wrStrobe = psel & penable & pwrite;
      rdSetup  = psel & ~penable & ~pwrite;
      unique case (paddr)
         timer_cmp_pkg::ADDR_CTRL, timer_cmp_pkg::ADDR_COUNT,
         timer_cmp_pkg::ADDR_CMP_A, timer_cmp_pkg::ADDR_CMP_B,
         timer_cmp_pkg::ADDR_ACTION, timer_cmp_pkg::ADDR_FORCE,
         timer_cmp_pkg::ADDR_FLAGS, timer_cmp_pkg::ADDR_IRQ_EN: addrOk = 1'b1;
         default: addrOk = 1'b0;
      endcase
      cntWrite = wrStrobe & (paddr == timer_cmp_pkg::ADDR_COUNT);
   end

   // Zero wait state answer, error on unmapped address
   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~addrOk;
   assign prdata  = prdata_q;

   // ***************************************************************
   // Mode decode and counter limits
   // ***************************************************************
   always_comb begin
      modeNormal = (waveformSelect_q == timer_cmp_pkg::WGM_NORMAL);
      modeCtc    = (waveformSelect_q == timer_cmp_pkg::WGM_CTC);
      modeFast   = (waveformSelect_q == timer_cmp_pkg::WGM_FAST_MAX) ||
                   (waveformSelect_q == timer_cmp_pkg::WGM_FAST_CMP);
      modePhase  = (waveformSelect_q == timer_cmp_pkg::WGM_PHASE_MAX) ||
                   (waveformSelect_q == timer_cmp_pkg::WGM_PHASE_CMP);
      topFromA   = (waveformSelect_q == timer_cmp_pkg::WGM_FAST_CMP) ||
                   (waveformSelect_q == timer_cmp_pkg::WGM_PHASE_CMP) || modeCtc;
      topValue   = topFromA ? compareActiveA : timer_cmp_pkg::CNT_MAX;
      atTop      = (counterValue_q == topValue);
      atBottom   = (counterValue_q == timer_cmp_pkg::CNT_BOTTOM);
   end

   // ***************************************************************
   // Counter, direction, wrap flag and match block
   // ***************************************************************
   always_comb begin
      counterValue_d = counterValue_q;
      dir_d          = dir_q;
      wrapEvt        = 1'b0;
      block_d        = cntWrite;
      if (cntWrite) begin
         counterValue_d = pwdata[7:0];
      end else if (run_q) begin
         if (modePhase) begin
            if (dir_q == timer_cmp_pkg::DIR_UP && atTop) begin
               dir_d          = timer_cmp_pkg::DIR_DOWN;
               counterValue_d = counterValue_q - timer_cmp_pkg::CNT_ONE;
            end else if (dir_q == timer_cmp_pkg::DIR_DOWN && atBottom) begin
               dir_d          = timer_cmp_pkg::DIR_UP;
               counterValue_d = counterValue_q + timer_cmp_pkg::CNT_ONE;
               wrapEvt        = 1'b1;
            end else if (dir_q == timer_cmp_pkg::DIR_DOWN) begin
               counterValue_d = counterValue_q - timer_cmp_pkg::CNT_ONE;
            end else begin
               counterValue_d = counterValue_q + timer_cmp_pkg::CNT_ONE;
            end
         end else if ((modeFast || modeCtc) && atTop) begin
            counterValue_d = timer_cmp_pkg::CNT_BOTTOM;
            wrapEvt        = modeFast || (counterValue_q == timer_cmp_pkg::CNT_MAX);
         end else begin
            counterValue_d = counterValue_q + timer_cmp_pkg::CNT_ONE;
            wrapEvt        = (counterValue_q == timer_cmp_pkg::CNT_MAX);
         end
      end
      if (!modePhase) begin
         dir_d = timer_cmp_pkg::DIR_UP;
      end
      // Hardware set wins over software and service clear
      wrapFlag_d = wrapEvt | (wrapFlag_q & ~irqAck[timer_cmp_pkg::FLAG_WRAP_BIT] &
                   ~(wrStrobe && paddr == timer_cmp_pkg::ADDR_FLAGS &&
                     pwdata[timer_cmp_pkg::FLAG_WRAP_BIT]));
   end

   // ***************************************************************
   // Control registers and read data
   // ***************************************************************
   always_comb begin
      waveformSelect_d     = waveformSelect_q;
      run_d                = run_q;
      outputActionSelect_d = outputActionSelect_q;
      irqEn_d              = irqEn_q;
      if (wrStrobe && paddr == timer_cmp_pkg::ADDR_CTRL) begin
         waveformSelect_d = pwdata[timer_cmp_pkg::CTRL_WGM_LSB +: 3];
         run_d            = pwdata[timer_cmp_pkg::CTRL_RUN_BIT];
      end
      if (wrStrobe && paddr == timer_cmp_pkg::ADDR_ACTION) begin
         outputActionSelect_d = pwdata[3:0];
      end
      if (wrStrobe && paddr == timer_cmp_pkg::ADDR_IRQ_EN) begin
         irqEn_d = pwdata[2:0];
      end
      prdata_d = prdata_q;
      if (rdSetup) begin
         prdata_d = timer_cmp_pkg::RD_ZERO;
         unique case (paddr)
            timer_cmp_pkg::ADDR_CTRL:   prdata_d[3:0] = {run_q, waveformSelect_q};
            timer_cmp_pkg::ADDR_COUNT:  prdata_d[7:0] = counterValue_q;
            timer_cmp_pkg::ADDR_CMP_A:  prdata_d[7:0] = compareReadA;
            timer_cmp_pkg::ADDR_CMP_B:  prdata_d[7:0] = compareReadB;
            timer_cmp_pkg::ADDR_ACTION: prdata_d[3:0] = outputActionSelect_q;
            timer_cmp_pkg::ADDR_FLAGS:  prdata_d[2:0] = {wrapFlag_q, matchFlag};
            timer_cmp_pkg::ADDR_IRQ_EN: prdata_d[2:0] = irqEn_q;
            default:                    prdata_d = timer_cmp_pkg::RD_ZERO;
         endcase
      end
   end

   // Register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waveformSelect_q     <= timer_cmp_pkg::WGM_NORMAL;
         run_q                <= 1'b0;
         outputActionSelect_q <= 4'h0;
         irqEn_q              <= timer_cmp_pkg::RST_FLAGS;
         wrapFlag_q           <= 1'b0;
         counterValue_q       <= timer_cmp_pkg::RST_BYTE;
         block_q              <= 1'b0;
         dir_q                <= timer_cmp_pkg::DIR_UP;
         prdata_q             <= timer_cmp_pkg::RD_ZERO;
      end else begin
         waveformSelect_q     <= waveformSelect_d;
         run_q                <= run_d;
         outputActionSelect_q <= outputActionSelect_d;
         irqEn_q              <= irqEn_d;
         wrapFlag_q           <= wrapFlag_d;
         counterValue_q       <= counterValue_d;
         block_q              <= block_d;
         dir_q                <= dir_d;
         prdata_q             <= prdata_d;
      end
   end

   // ***************************************************************
   // Channel instances
   // ***************************************************************
   always_comb begin
      info.tick      = run_q;
      info.count     = counterValue_q;
      info.dblBuf    = modeFast | modePhase;
      info.pwmFast   = modeFast;
      info.pwmPhase  = modePhase;
      info.countDown = (dir_q == timer_cmp_pkg::DIR_DOWN);
      info.updateNow = run_q & ~cntWrite &
                       ((modeFast & atTop) |
                        (modePhase & atTop & (dir_q == timer_cmp_pkg::DIR_UP)));
      info.bottomEvt = run_q & ~cntWrite & modeFast & atTop;
      info.block     = block_q;
      ctlA.action    = outputActionSelect_q[timer_cmp_pkg::ACT_A_LSB +: 2];
      ctlB.action    = outputActionSelect_q[timer_cmp_pkg::ACT_B_LSB +: 2];
      ctlA.forceMatchStrobe = wrStrobe & (paddr == timer_cmp_pkg::ADDR_FORCE) &
                       pwdata[timer_cmp_pkg::CH_A];
      ctlB.forceMatchStrobe = wrStrobe & (paddr == timer_cmp_pkg::ADDR_FORCE) &
                       pwdata[timer_cmp_pkg::CH_B];
      ctlA.flagClear = irqAck[timer_cmp_pkg::CH_A] |
                       (wrStrobe & (paddr == timer_cmp_pkg::ADDR_FLAGS) &
                        pwdata[timer_cmp_pkg::CH_A]);
      ctlB.flagClear = irqAck[timer_cmp_pkg::CH_B] |
                       (wrStrobe & (paddr == timer_cmp_pkg::ADDR_FLAGS) &
                        pwdata[timer_cmp_pkg::CH_B]);
      ctlA.wrEn      = wrStrobe & (paddr == timer_cmp_pkg::ADDR_CMP_A);
      ctlB.wrEn      = wrStrobe & (paddr == timer_cmp_pkg::ADDR_CMP_B);
      ctlA.wrData    = pwdata[7:0];
      ctlB.wrData    = pwdata[7:0];
   end

   // Channel A also supplies the top value
   compare_channel chanA (
      .clk           (clk),
      .rst           (rst),
      .info          (info),
      .ctl           (ctlA),
      .compareActive (compareActiveA),
      .compareRead   (compareReadA),
      .matchFlag     (matchFlag[timer_cmp_pkg::CH_A]),
      .outputState   (outputState[timer_cmp_pkg::CH_A])
   );

   // Channel B
   compare_channel chanB (
      .clk           (clk),
      .rst           (rst),
      .info          (info),
      .ctl           (ctlB),
      .compareActive (),
      .compareRead   (compareReadB),
      .matchFlag     (matchFlag[timer_cmp_pkg::CH_B]),
      .outputState   (outputState[timer_cmp_pkg::CH_B])
   );

   // ***************************************************************
   // Interrupt requests and pin override
   // ***************************************************************
   assign irqReq = {wrapFlag_q, matchFlag} & irqEn_q;
   assign pinOut[0] = (|outputActionSelect_q[1:0]) ? outputState[0] : portOut[0];
   assign pinOut[1] = (|outputActionSelect_q[3:2]) ? outputState[1] : portOut[1];
   assign pinOe  = outputPinDirectionBit;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence cntWriteSeq;
      wrStrobe && paddr == timer_cmp_pkg::ADDR_COUNT;
   endsequence

   sequence normalWrapSeq;
      run_q && modeNormal && !cntWrite && counterValue_q == timer_cmp_pkg::CNT_MAX;
   endsequence

   count_write_block_a: assert property (
      cntWriteSeq |=> (block_q && counterValue_q == $past(pwdata[7:0])))
      else $error("counter write not taken or match not blocked");

   normal_wrap_a: assert property (
      normalWrapSeq |=> (counterValue_q == timer_cmp_pkg::CNT_BOTTOM && wrapFlag_q))
      else $error("normal mode wrap did not clear counter and set flag");

   ctc_clear_a: assert property (
      (run_q && modeCtc && !cntWrite && counterValue_q == compareActiveA)
      |=> counterValue_q == timer_cmp_pkg::CNT_BOTTOM)
      else $error("clear on match mode did not clear counter");

   irq_raise_a: assert property (
      (run_q && counterValue_q == compareActiveA && !block_q &&
       irqEn_q[timer_cmp_pkg::CH_A] && !(wrStrobe && paddr == timer_cmp_pkg::ADDR_IRQ_EN))
      |=> irqReq[timer_cmp_pkg::CH_A])
      else $error("enabled match flag raised no request");

   flag_w1c_a: assert property (
      (wrStrobe && paddr == timer_cmp_pkg::ADDR_FLAGS && pwdata[timer_cmp_pkg::CH_A]
       && !(run_q && counterValue_q == compareActiveA && !block_q))
      |=> !matchFlag[timer_cmp_pkg::CH_A])
      else $error("write one did not clear match flag");

   normal_count_up_a: assert property (
      (run_q && modeNormal && !cntWrite)
      |=> counterValue_q == $past(counterValue_q) + timer_cmp_pkg::CNT_ONE)
      else $error("normal mode did not count up by one");

   wrap_flag_hold_a: assert property (
      (wrapFlag_q && !irqAck[timer_cmp_pkg::FLAG_WRAP_BIT] &&
       !(wrStrobe && paddr == timer_cmp_pkg::ADDR_FLAGS &&
         pwdata[timer_cmp_pkg::FLAG_WRAP_BIT]))
      |=> wrapFlag_q)
      else $error("wrap flag cleared without service or write");

   phase_turn_a: assert property (
      (run_q && modePhase && !cntWrite && atTop && dir_q == timer_cmp_pkg::DIR_UP)
      |=> (dir_q == timer_cmp_pkg::DIR_DOWN) ##1 (dir_q == timer_cmp_pkg::DIR_DOWN
          || !modePhase || $past(atBottom)))
      else $error("phase correct mode did not turn at top");

   pin_override_a: assert property (
      (outputActionSelect_q[1:0] != timer_cmp_pkg::ACT_NONE) |-> pinOut[0] == outputState[0])
      else $error("output state not driven on pin");

endmodule // timer_compare_output_unit

`default_nettype wire

// ===== tb/port_model.sv
`timescale 1ns/1ps
`default_nettype none
// **********
// CPU and port side of the unit
// **********
module port_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ackOn,
   input  wire logic [2:0] irqReq,
   output logic [2:0]      irqAck,
   output logic [1:0]      portOut,
   output logic [1:0]      dirBits
);
   // Service each raised request with a one-cycle pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqAck <= 3'h0;
      end else begin
         irqAck <= ackOn ? (irqReq & ~irqAck) : 3'h0;
      end
   end
   // Port value differs per pin; both pins set as outputs
   assign portOut = 2'h2;
   assign dirBits = 2'h3;
endmodule // port_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// **********
// Register-level tests of the compare unit
// **********
module tb_top;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ackOn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, lastErr;
   logic [2:0]  irqAck, irqReq;
   logic [1:0]  portOut, dirBits, pinOut, pinOe;
   int          errors = 0, checked = 0;
   timer_compare_output_unit DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irqAck(irqAck), .irqReq(irqReq), .portOut(portOut),
      .outputPinDirectionBit(dirBits), .pinOut(pinOut), .pinOe(pinOe));
   port_model cpu (.clk(clk), .rst(rst), .ackOn(ackOn), .irqReq(irqReq), .irqAck(irqAck),
      .portOut(portOut), .dirBits(dirBits));
   // Clock at 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      lastErr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask
   task automatic close_out();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #300000;
      errors++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(8'h20, 32'h0);
      chk(32'(lastErr), 32'h1);
      chk(32'(pinOut), 32'h2);
      wr(timer_cmp_pkg::ADDR_ACTION, 32'hD);
      chk(32'(pinOut), 32'h0);
      wr(timer_cmp_pkg::ADDR_FORCE, 32'h1);
      chk(32'(pinOut), 32'h1);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h0);
      rd(timer_cmp_pkg::ADDR_COUNT, 32'h0);
      wr(timer_cmp_pkg::ADDR_CMP_A, 32'h5);
      wr(timer_cmp_pkg::ADDR_CMP_B, 32'h80);
      wr(timer_cmp_pkg::ADDR_COUNT, 32'h3);
      wr(timer_cmp_pkg::ADDR_IRQ_EN, 32'h7);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h8);
      repeat (4) @(posedge clk);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h1);
      chk(32'(irqReq), 32'h1);
      chk(32'(pinOut), 32'h0);
      wr(timer_cmp_pkg::ADDR_FLAGS, 32'h1);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h0);
      wr(timer_cmp_pkg::ADDR_CMP_B, 32'h0);
      wr(timer_cmp_pkg::ADDR_COUNT, 32'hFE);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h8);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h6);
      chk(32'(pinOut), 32'h2);
      ackOn <= 1'b1;
      repeat (4) @(posedge clk);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h0);
      ackOn <= 1'b0;
      wr(timer_cmp_pkg::ADDR_CMP_A, 32'h40);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h8);
      wr(timer_cmp_pkg::ADDR_COUNT, 32'h40);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h0);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h3);
      chk(32'(pinOut), 32'h2);
      chk(32'(pinOe), 32'h3);
      wr(timer_cmp_pkg::ADDR_CMP_B, 32'h22);
      rd(timer_cmp_pkg::ADDR_CMP_B, 32'h22);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(timer_cmp_pkg::ADDR_CMP_B, 32'h0);
      wr(timer_cmp_pkg::ADDR_COUNT, 32'h3E);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'hA);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h2);
      rd(timer_cmp_pkg::ADDR_COUNT, 32'h0);
      rd(timer_cmp_pkg::ADDR_FLAGS, 32'h1);
      chk(32'(pinOut), 32'h3);
      wr(timer_cmp_pkg::ADDR_COUNT, 32'hFD);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h9);
      repeat (2) @(posedge clk);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h1);
      rd(timer_cmp_pkg::ADDR_COUNT, 32'hFC);
      wr(timer_cmp_pkg::ADDR_CTRL, 32'h0);
      rd(timer_cmp_pkg::ADDR_CMP_B, 32'h22);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
